//--- rtl/system_clock_select_control.sv
// clock source select, dividers and pll stabilisation for cpu and peripherals
//
// Contract
// - reset gives cpu and fast clock divide by 16
// - cpu divider field picks /2 /4 /8 /16
// - port clock divider picks /1 /2 /4 /8
// - source bit: 0 slow, 1 fast; resets 1
// - oscillator off forces source bit to 0
// - enable bit starts and stops pll; resets 1
// - ready flag high only when pll usable
// - ready low while stopped or still counting
// - ready flag is read only
// - byte and word access, reset value 0x33
// - selected clock to cpu, others to peripherals
// - count 16384 pll pulses before pll supply
// - slow clock withheld for 128 slow cycles
// - pll runs at 500 times slow clock; the code gives 250 times (pll is clk/2, slow clock is clk/500)
`timescale 1ns/1ps

module system_clock_select_control #(
    parameter int PLL_STAB_PULSES = clock_ctrl_pkg::PLL_STAB_PULSES
) (
    input wire logic clk,                               // reference clock
    input wire logic rst,                               // async reset, high
    input wire clock_ctrl_pkg::bus_req_t bus,           // register request
    output logic [15:0] rdata,                          // read data, cycle after rd
    output clock_ctrl_pkg::clock_out_t clocks,          // generated clocks
    output logic pll_ready                              // pll usable
);
    import clock_ctrl_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    localparam logic [14:0] STAB_TARGET = 15'(PLL_STAB_PULSES);

    // tap n of the chain counter is the pll clock divided by 2**n
    function automatic logic clk_tap(input logic [4:0] cnt, input logic [2:0] tap);
        logic r;
        r = 1'b0;
        if (tap <= 3'h4) begin
            r = cnt[tap];
        end
        return r;
    endfunction

    function automatic logic [7:0] divider_byte(input ctrl_state_t s);
        logic [7:0] b;
        b = 8'h00;
        b[CPU_DIV_SEL_LO_POS +: 2] = s.cpu_div;
        b[PORT_CLK_DIV_SEL_LO_POS +: 2] = s.port_div;
        return b;
    endfunction

    function automatic logic [7:0] source_byte(input ctrl_state_t s);
        logic [7:0] b;
        b = 8'h00;
        b[CPU_SRC_SEL_POS] = s.src_sel;
        b[FAST_OSC_ENABLE_POS] = s.osc_en;
        b[PLL_READY_FLAG_POS] = s.ready;
        return b;
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    ctrl_state_t state_reg;
    ctrl_state_t state_next;

    always_comb begin
        logic hit_div;
        logic hit_src;
        logic hit_word;
        logic wr_div;
        logic wr_src;
        logic [7:0] src_byte;
        logic wrap;
        logic slow_fall;
        logic want_fast;
        logic fast_cpu;
        logic slow_out;
        hit_div = 1'b0;
        hit_src = 1'b0;
        hit_word = 1'b0;
        wr_div = 1'b0;
        wr_src = 1'b0;
        src_byte = 8'h00;
        wrap = 1'b0;
        slow_fall = 1'b0;
        want_fast = 1'b0;
        fast_cpu = 1'b0;
        slow_out = 1'b0;
        state_next = state_reg;

        // -----------------------------------------------------------
        // register decode
        // -----------------------------------------------------------
        // a word access only lands on the even address; it covers both
        hit_word = bus.word && (bus.addr == CLOCK_DIVIDER_SELECT_ADDR);
        hit_div = !bus.word && (bus.addr == CLOCK_DIVIDER_SELECT_ADDR);
        hit_src = !bus.word && (bus.addr == CLOCK_SOURCE_CONTROL_ADDR);
        wr_div = bus.wr && (hit_div || hit_word);
        wr_src = bus.wr && (hit_src || hit_word);
        src_byte = hit_word ? bus.wdata[15:8] : bus.wdata[7:0];

        if (wr_div) begin
            state_next.cpu_div = bus.wdata[CPU_DIV_SEL_LO_POS +: 2];
            state_next.port_div = bus.wdata[PORT_CLK_DIV_SEL_LO_POS +: 2];
        end
        // the ready flag position is never written
        if (wr_src) begin
            state_next.osc_en = src_byte[FAST_OSC_ENABLE_POS];
            state_next.src_sel = src_byte[CPU_SRC_SEL_POS];
        end
        // source bit sticks at 0 whenever the oscillator is off
        if (!state_next.osc_en) begin
            state_next.src_sel = 1'b0;
        end

        state_next.rdata = 16'h0000;
        if (bus.rd) begin
            if (hit_word) begin
                state_next.rdata = {source_byte(state_reg), divider_byte(state_reg)};
            end else if (hit_div) begin
                state_next.rdata = {8'h00, divider_byte(state_reg)};
            end else if (hit_src) begin
                state_next.rdata = {8'h00, source_byte(state_reg)};
            end
        end

        // -----------------------------------------------------------
        // pll chain counter and stabilisation
        // -----------------------------------------------------------
        // bit 0 of the chain is the pll clock itself, half of clk
        wrap = (state_reg.div_cnt == DIV_CNT_LAST);
        // once stopped the chain finishes its round so all taps end low
        if (state_reg.osc_en || (state_reg.div_cnt != 5'h00)) begin
            state_next.div_cnt = 5'(state_reg.div_cnt + 5'h01);
        end
        if (!state_reg.osc_en) begin
            state_next.stab_cnt = 15'h0000;
        end else if (!state_reg.div_cnt[0] && (state_reg.stab_cnt != STAB_TARGET)) begin
            state_next.stab_cnt = 15'(state_reg.stab_cnt + 15'h0001);
        end
        state_next.ready = state_reg.osc_en && (state_reg.stab_cnt == STAB_TARGET);

        // dividers and the fast gate only change where every tap falls
        if (wrap) begin
            state_next.cpu_div_act = state_reg.cpu_div;
            state_next.port_div_act = state_reg.port_div;
            state_next.fast_on = state_reg.ready;
        end

        // -----------------------------------------------------------
        // slow clock
        // -----------------------------------------------------------
        // slow clock is the pll reference: pll rate / 250 (clk / 500)
        if (state_reg.slow_div_cnt == SLOW_HALF_LAST) begin
            state_next.slow_div_cnt = 8'h00;
            state_next.slow_lvl = !state_reg.slow_lvl;
            slow_fall = state_reg.slow_lvl;
        end else begin
            state_next.slow_div_cnt = 8'(state_reg.slow_div_cnt + 8'h01);
        end
        // gate opens on a falling edge, so the first high phase is whole
        if (slow_fall && !state_reg.slow_ok) begin
            state_next.slow_cnt = 8'(state_reg.slow_cnt + 8'h01);
            if (8'(state_reg.slow_cnt + 8'h01) == SLOW_STAB_CNT) begin
                state_next.slow_ok = 1'b1;
            end
        end
        slow_out = state_next.slow_lvl && state_next.slow_ok;

        // -----------------------------------------------------------
        // cpu source switch
        // -----------------------------------------------------------
        want_fast = state_reg.src_sel && state_reg.osc_en;
        fast_cpu = clk_tap(state_next.div_cnt, 3'({1'b0, state_next.cpu_div_act} + 3'h1))
            && state_next.fast_on;
        state_next.clocks.cpu_clock = 1'b0;
        // the cpu clock is parked low between sources; the cpu stalls
        // until the new source is running
        unique case (state_reg.src_state)
            SRC_SLOW: begin
                state_next.clocks.cpu_clock = slow_out;
                if (want_fast && slow_fall) begin
                    state_next.src_state = SRC_TO_FAST;
                    state_next.clocks.cpu_clock = 1'b0;
                end
            end
            SRC_TO_FAST: begin
                if (!want_fast) begin
                    state_next.src_state = SRC_TO_SLOW;
                end else if (wrap && state_reg.ready) begin
                    state_next.src_state = SRC_FAST;
                    state_next.clocks.cpu_clock = fast_cpu;
                end
            end
            SRC_FAST: begin
                state_next.clocks.cpu_clock = fast_cpu;
                if (!want_fast && wrap) begin
                    state_next.src_state = SRC_TO_SLOW;
                    state_next.clocks.cpu_clock = 1'b0;
                end
            end
            SRC_TO_SLOW: begin
                if (want_fast) begin
                    state_next.src_state = SRC_TO_FAST;
                end else if (slow_fall && state_reg.slow_ok) begin
                    state_next.src_state = SRC_SLOW;
                end
            end
        endcase

        // -----------------------------------------------------------
        // peripheral and port clocks
        // -----------------------------------------------------------
        state_next.clocks.fast_peripheral_clock = fast_cpu;
        state_next.clocks.slow_clock = slow_out;
        state_next.clocks.port_fast_clock_out =
            clk_tap(state_next.div_cnt, {1'b0, state_next.port_div_act}) && state_next.fast_on;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= CTRL_STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign rdata = state_reg.rdata;
    assign clocks = state_reg.clocks;
    assign pll_ready = state_reg.ready;

endmodule

//--- rtl/clock_ctrl_pkg.sv
// shared constants and types of the clock select and divider control
package clock_ctrl_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [15:0] CLOCK_DIVIDER_SELECT_ADDR = 16'hf002;
    localparam logic [15:0] CLOCK_SOURCE_CONTROL_ADDR = 16'hf003;
    localparam logic [7:0] CLOCK_DIVIDER_SELECT_RST = 8'h33;
    localparam logic [7:0] CLOCK_SOURCE_CONTROL_RST = 8'h83;

    // clock_divider_select fields
    localparam int CPU_DIV_SEL_LO_POS = 0;
    localparam int PORT_CLK_DIV_SEL_LO_POS = 4;
    // clock_source_control fields
    localparam int CPU_SRC_SEL_POS = 0;
    localparam int FAST_OSC_ENABLE_POS = 1;
    localparam int PLL_READY_FLAG_POS = 7;

    localparam logic [1:0] CPU_DIV_RST = 2'h3;
    localparam logic [1:0] PORT_DIV_RST = 2'h3;

    // ---------------------------------------------------------------
    // timing counts
    // ---------------------------------------------------------------
    localparam int PLL_STAB_PULSES = 16384;
    localparam int SLOW_STAB_CYCLES = 128;
    localparam int PLL_MULT = 500;
    localparam logic [7:0] SLOW_STAB_CNT = 8'(SLOW_STAB_CYCLES);
    // last count of the slow clock half period in cycles of clk
    localparam logic [7:0] SLOW_HALF_LAST = 8'(PLL_MULT / 2 - 1);
    localparam logic [4:0] DIV_CNT_LAST = 5'h1f;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        SRC_SLOW = 4'h1,
        SRC_TO_FAST = 4'h2,
        SRC_FAST = 4'h4,
        SRC_TO_SLOW = 4'h8
    } cpu_src_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
        logic word;
    } bus_req_t;

    typedef struct packed {
        logic cpu_clock;
        logic fast_peripheral_clock;
        logic slow_clock;
        logic port_fast_clock_out;
    } clock_out_t;

    typedef struct packed {
        logic [4:0] div_cnt;
        logic [1:0] cpu_div;
        logic [1:0] port_div;
        logic [1:0] cpu_div_act;
        logic [1:0] port_div_act;
        logic src_sel;
        logic osc_en;
        logic [14:0] stab_cnt;
        logic ready;
        logic fast_on;
        logic [7:0] slow_div_cnt;
        logic slow_lvl;
        logic [7:0] slow_cnt;
        logic slow_ok;
        cpu_src_state_t src_state;
        clock_out_t clocks;
        logic [15:0] rdata;
    } ctrl_state_t;

    localparam ctrl_state_t CTRL_STATE_RST = '{
        div_cnt: 5'h00,
        cpu_div: CPU_DIV_RST,
        port_div: PORT_DIV_RST,
        cpu_div_act: CPU_DIV_RST,
        port_div_act: PORT_DIV_RST,
        src_sel: 1'b1,
        osc_en: 1'b1,
        stab_cnt: 15'h0000,
        ready: 1'b0,
        fast_on: 1'b0,
        slow_div_cnt: 8'h00,
        slow_lvl: 1'b0,
        slow_cnt: 8'h00,
        slow_ok: 1'b0,
        src_state: SRC_TO_FAST,
        clocks: 4'h0,
        rdata: 16'h0000
    };

endpackage

//--- tb/clock_select_assertions.sv
// concurrent checks on the ports of the clock select control
`timescale 1ns/1ps
module clock_select_checker #(
    parameter int PLL_STAB_PULSES = 8
) (
    input wire logic clk, // reference clock
    input wire logic rst, // async reset
    input wire clock_ctrl_pkg::bus_req_t bus, // register request
    input wire logic [15:0] rdata, // read data
    input wire clock_ctrl_pkg::clock_out_t clocks, // generated clocks
    input wire logic pll_ready // ready flag
);
    import clock_ctrl_pkg::*;
    localparam int SLOW_WAIT = SLOW_STAB_CYCLES * PLL_MULT;
    logic [15:0] since_wr;
    logic [15:0] up_cnt;
    logic src_wr;
    logic dis_wr;
    logic f3_rd;
    logic bad_rd;
    assign src_wr = bus.wr && (bus.addr == CLOCK_SOURCE_CONTROL_ADDR && !bus.word
        || bus.addr == CLOCK_DIVIDER_SELECT_ADDR && bus.word);
    assign dis_wr = src_wr && !(bus.word ? bus.wdata[9] : bus.wdata[1]);
    assign f3_rd = bus.rd && bus.addr == CLOCK_SOURCE_CONTROL_ADDR && !bus.word;
    assign bad_rd = bus.rd && bus.addr != CLOCK_DIVIDER_SELECT_ADDR && !f3_rd;
    // saturating, so long idle stretches never wrap back under the bound
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            since_wr <= 16'h0;
            up_cnt <= 16'h0;
        end else begin
            since_wr <= src_wr ? 16'h0 : since_wr + 16'(since_wr != 16'hffff);
            up_cnt <= up_cnt + 16'(up_cnt != 16'hffff);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // the write lands at the strobe edge and the flag follows one edge later
    ready_drop_a: assert property (dis_wr |-> ##2 !pll_ready)
        else $error("ready flag high after oscillator stop");
    ready_wait_a: assert property ($rose(pll_ready) |-> since_wr >= 16'(2 * PLL_STAB_PULSES - 2))
        else $error("ready flag rose before stabilisation count");
    unmapped_zero_a: assert property (bad_rd |=> rdata == 16'h0)
        else $error("unmapped read returned data");
    idle_zero_a: assert property (!bus.rd |=> rdata == 16'h0)
        else $error("read data without a read");
    flag_ro_a: assert property (f3_rd |=> rdata[7] == $past(pll_ready) && rdata[6:2] == 5'h0)
        else $error("ready bit does not follow the flag");
    src_forced_a: assert property (f3_rd |=> !(rdata[0] && !rdata[1]))
        else $error("fast source kept with oscillator off");
    cpu_high_a: assert property ($rose(clocks.cpu_clock) |=> clocks.cpu_clock)
        else $error("short high pulse on cpu clock");
    cpu_low_a: assert property ($fell(clocks.cpu_clock) |=> !clocks.cpu_clock)
        else $error("short low pulse on cpu clock");
    fast_high_a: assert property ($rose(clocks.fast_peripheral_clock) |=> clocks.fast_peripheral_clock)
        else $error("short high pulse on fast clock");
    slow_hold_a: assert property (up_cnt < 16'(SLOW_WAIT) |-> !clocks.slow_clock)
        else $error("slow clock before stabilisation");
    cover property ($rose(pll_ready));
    cover property (dis_wr);
    cover property ($rose(clocks.slow_clock));
endmodule

bind system_clock_select_control clock_select_checker #(.PLL_STAB_PULSES(PLL_STAB_PULSES)) i_clock_select_checker (
    .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .clocks(clocks), .pll_ready(pll_ready));

//--- tb/clock_consumer_model.sv
// cpu and peripheral side: measures the period of each clock it consumes
`timescale 1ns/1ps
module clock_consumer_model (
    input wire logic clk, // reference clock
    input wire logic rst, // async reset
    input wire clock_ctrl_pkg::clock_out_t clocks, // clocks consumed
    output logic [3:0][15:0] per // last period of each clock in clk cycles
);
    import clock_ctrl_pkg::*;
    logic [3:0][15:0] cnt;
    logic [3:0] prev;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
            per <= '0;
            prev <= '0;
        end else begin
            prev <= clocks;
            for (int i = 0; i < 4; i++) begin
                cnt[i] <= cnt[i] + 16'h1;
                if (clocks[i] && !prev[i]) begin
                    per[i] <= cnt[i] + 16'h1;
                    cnt[i] <= 16'h0;
                end
            end
        end
    end
endmodule

//--- tb/testbench.sv
// self-checking bench for the clock select control
`timescale 1ns/1ps
module testbench;
    import clock_ctrl_pkg::*;
    localparam int STAB = 8;
    localparam logic [15:0] DIV = CLOCK_DIVIDER_SELECT_ADDR;
    localparam logic [15:0] SRC = CLOCK_SOURCE_CONTROL_ADDR;
    logic clk = 1'b0;
    logic rst = 1'b1;
    bus_req_t bus = '0;
    logic [15:0] rdata;
    clock_out_t clocks;
    logic pll_ready;
    logic [3:0][15:0] per;
    logic [15:0] exp_q[$];
    logic pend = 1'b0;
    logic [7:0] r;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    system_clock_select_control #(.PLL_STAB_PULSES(STAB)) i_system_clock_select_control (
        .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .clocks(clocks), .pll_ready(pll_ready));
    clock_consumer_model i_clock_consumer_model (.clk(clk), .rst(rst), .clocks(clocks), .per(per));
    task automatic chk(string what, logic [15:0] e, logic [15:0] s);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one access; a read leaves its expected data in the queue
    task automatic acc(logic w, logic [15:0] a, logic [15:0] d, logic wd, logic [15:0] e);
        if (!w)
            exp_q.push_back(e);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w, word: wd};
        @(posedge clk);
        bus.wr <= 1'b0;
        bus.rd <= 1'b0;
    endtask
    task automatic wait_ready;
        for (int i = 0; i < 300 && pll_ready !== 1'b1; i++)
            @(posedge clk);
    endtask
    task automatic periods(logic [15:0] c, logic [15:0] p);
        repeat (200) @(posedge clk);
        chk("cpu period", c, per[3]);
        chk("fast period", c, per[2]);
        chk("port period", p, per[0]);
    endtask
    // ---------------------------------------------------------------
    // read data monitor and run limit
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        if (pend)
            chk("rdata", exp_q.pop_front(), rdata);
        pend <= bus.rd;
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(27640));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        acc(0, DIV, 16'h0, 0, 16'h0033);
        acc(0, SRC, 16'h0, 0, 16'h0003);
        wait_ready();
        chk("ready", 16'h1, pll_ready);
        acc(0, SRC, 16'h0, 0, 16'h0083);
        acc(0, DIV, 16'h0, 1, 16'h8333);
        acc(0, SRC, 16'h0, 1, 16'h0000);
        periods(16'd32, 16'd16);
        for (int d = 0; d < 4; d++) begin
            r = (8'($urandom) & 8'hcc) | 8'(d) | 8'((3 - d) << 4);
            acc(1, DIV, {8'($urandom), r}, 0, 16'h0);
            acc(0, DIV, 16'h0, 0, 16'(r & 8'h33));
            acc(0, 16'hf004 + 16'($urandom_range(0, 255)), 16'h0, 1'($urandom), 16'h0);
            periods(16'(4 << d), 16'(2 << (3 - d)));
        end
        acc(1, SRC, 16'h0081, 0, 16'h0);
        acc(0, SRC, 16'h0, 0, 16'h0000);
        chk("ready", 16'h0, pll_ready);
        // slow clock only appears after its long stabilisation
        for (int i = 0; i < 66000 && per[1] == 16'h0; i++)
            @(posedge clk);
        repeat (1200) @(posedge clk);
        chk("slow period", 16'(PLL_MULT), per[1]);
        chk("cpu on slow", 16'(PLL_MULT), per[3]);
        acc(1, SRC, 16'h0003, 0, 16'h0);
        wait_ready();
        chk("ready", 16'h1, pll_ready);
        repeat (700) @(posedge clk);
        chk("cpu on fast", 16'd32, per[3]);
        acc(0, SRC, 16'h0, 0, 16'h0083);
        // word write reaches both registers; the ready bit is not written
        acc(1, DIV, 16'h0303, 1, 16'h0);
        acc(0, DIV, 16'h0, 1, 16'h8303);
        stop_test();
    end
endmodule
